/* design/bpc_pkg.sv */
// Shared constants for the battery protection configuration block.
// Assumes a single clock domain; registers are 16-bit words at word indexes.
package bpc_pkg;
  // Register indexes
  localparam logic [4:0] BPC_OFF_EN_A    = 5'h00;
  localparam logic [4:0] BPC_OFF_EN_B    = 5'h01;
  localparam logic [4:0] BPC_OFF_DSG     = 5'h02;
  localparam logic [4:0] BPC_OFF_BOTH    = 5'h03;
  localparam logic [4:0] BPC_OFF_OW      = 5'h04;
  localparam logic [4:0] BPC_OFF_UV_THR  = 5'h05;
  localparam logic [4:0] BPC_OFF_UV_DLY  = 5'h06;
  localparam logic [4:0] BPC_OFF_UV_HYS  = 5'h07;
  localparam logic [4:0] BPC_OFF_OV_THR  = 5'h08;
  localparam logic [4:0] BPC_OFF_OV_DLY  = 5'h09;
  localparam logic [4:0] BPC_OFF_OV_HYS  = 5'h0A;
  localparam logic [4:0] BPC_OFF_RECOVER = 5'h0B;
  localparam logic [4:0] BPC_OFF_STAT_A  = 5'h0C;
  localparam logic [4:0] BPC_OFF_STAT_B  = 5'h0D;
  localparam logic [4:0] BPC_OFF_EVT     = 5'h0E;
  localparam logic [4:0] BPC_OFF_EVT_CLR = 5'h0F;
  localparam logic [4:0] BPC_OFF_EVT_EN  = 5'h10;
  // Reset values
  localparam logic [7:0]  BPC_RST_EN_A   = 8'hA1;
  localparam logic [7:0]  BPC_RST_EN_B   = 8'h00;
  localparam logic [7:0]  BPC_RST_DSG    = 8'hFF;
  localparam logic [7:0]  BPC_RST_BOTH   = 8'h06;
  localparam logic [7:0]  BPC_RST_OW     = 8'h10;
  localparam logic [15:0] BPC_RST_UV_THR = 16'h09C4;
  localparam logic [15:0] BPC_RST_OV_THR = 16'h1068;
  localparam logic [7:0]  BPC_RST_DLY    = 8'h0A;
  localparam logic [1:0]  BPC_RST_HYS    = 2'h2;
  // Writable bits and forced-one bits
  localparam logic [7:0]  BPC_EN_B_WMASK = 8'h3E;
  localparam logic [7:0]  BPC_BOTH_WMASK = 8'h07;
  localparam logic [7:0]  BPC_OW_WMASK   = 8'h0F;
  localparam logic [7:0]  BPC_OW_ONES    = 8'h10;
  // Field positions
  localparam int BPC_A_OV    = 7;
  localparam int BPC_A_UV    = 6;
  localparam int BPC_A_SC    = 5;
  localparam int BPC_A_OC1   = 4;
  localparam int BPC_A_OC2   = 3;
  localparam int BPC_A_REG   = 0;
  localparam int BPC_B_OTD   = 5;
  localparam int BPC_B_UTD   = 3;
  localparam int BPC_B_OTI   = 1;
  localparam int BPC_OW_EN   = 3;
  localparam logic [2:0] BPC_OW_RATE_MAX = 3'h7;
  localparam logic [2:0] BPC_OW_DIV_MASK = 3'h7;
  // Hysteresis steps in millivolts
  localparam logic [15:0] BPC_HYS_50  = 16'h0032;
  localparam logic [15:0] BPC_HYS_100 = 16'h0064;
  localparam logic [15:0] BPC_HYS_200 = 16'h00C8;

  typedef enum logic {BPC_CLEAR, BPC_TRIPPED} bpc_fstate_t;

  // Recovery hysteresis code to millivolts; code 0 disables recovery
  function automatic logic [15:0] bpc_hyst_mv(input logic [1:0] code);
    case (code)
      2'h1:    bpc_hyst_mv = BPC_HYS_50;
      2'h2:    bpc_hyst_mv = BPC_HYS_100;
      2'h3:    bpc_hyst_mv = BPC_HYS_200;
      default: bpc_hyst_mv = 16'h0000;
    endcase
  endfunction
endpackage

/* design/bpc_ow_sched.sv */
// Open-wire current source scheduler.
// Assumes check_tick once per CHECK interval and sub_tick 16 times per interval.
`timescale 1ns/10ps
`default_nettype none
module bpc_ow_sched (
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       check_tick,
  input  wire logic       sub_tick,
  input  wire logic       enable,
  input  wire logic [2:0] rate,
  output logic            pulse
);
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic       next_pulse;
  logic [2:0] mask;
  logic       tick;

  ////////////////////////////////////////////////////////////////
  // Upper codes count sub-ticks, lower codes count whole intervals
  always_comb begin
    tick       = rate[2] ? sub_tick : check_tick;
    mask       = bpc_pkg::BPC_OW_DIV_MASK >> rate[1:0];
    next_cnt   = cnt;
    next_pulse = 1'b0;
    if (!enable) begin
      next_cnt = 3'h0;
    end else if (tick) begin
      next_cnt = cnt + 3'h1;
      if ((cnt & mask) == mask) begin
        next_pulse = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      cnt   <= 3'h0;
      pulse <= 1'b0;
    end else begin
      cnt   <= next_cnt;
      pulse <= next_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_OW_DISABLED: assert property (!enable |=> !pulse)
    else $error("open-wire source fired while disabled");
  AST_OW_EVERY: assert property (enable && rate == 3'h3 && check_tick |=> pulse)
    else $error("open-wire source missed a CHECK interval");
endmodule
`default_nettype wire

/* design/bpc_volt_eval.sv */
// Cell voltage fault evaluator with delay and hysteresis recovery.
// Assumes cell_mv is valid whenever check_tick pulses.
`timescale 1ns/10ps
`default_nettype none
module bpc_volt_eval #(
  parameter bit OVER = 1'b0
) (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              check_tick,
  input  wire logic              enable,
  input  wire logic signed [15:0] cell_mv,
  input  wire logic signed [15:0] threshold,
  input  wire logic [7:0]        delay,
  input  wire logic [1:0]        hyst,
  input  wire logic              recover,
  output logic                   fault
);
  bpc_pkg::bpc_fstate_t state;
  bpc_pkg::bpc_fstate_t next_state;
  logic [7:0]        cnt;
  logic [7:0]        next_cnt;
  logic signed [16:0] v;
  logic signed [16:0] thr;
  logic signed [16:0] hys;
  logic [7:0]        lim;
  logic              cond;
  logic              rec;

  ////////////////////////////////////////////////////////////////
  // Extra bit keeps threshold +/- hysteresis from wrapping
  always_comb begin
    v    = {cell_mv[15], cell_mv};
    thr  = {threshold[15], threshold};
    hys  = {1'b0, bpc_pkg::bpc_hyst_mv(hyst)};
    cond = OVER ? (v > thr) : (v < thr);
    rec  = OVER ? (v <= thr - hys) : (v >= thr + hys);
    lim  = (delay == 8'h00) ? 8'h01 : delay;
  end

  ////////////////////////////////////////////////////////////////
  // Delay counts consecutive CHECK hits; a miss restarts it
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      bpc_pkg::BPC_CLEAR: begin
        if (check_tick && cond) begin
          if (({1'b0, cnt} + 9'h001) >= {1'b0, lim}) begin
            next_state = bpc_pkg::BPC_TRIPPED;
            next_cnt   = 8'h00;
          end else begin
            next_cnt = cnt + 8'h01;
          end
        end else if (check_tick) begin
          next_cnt = 8'h00;
        end
      end
      bpc_pkg::BPC_TRIPPED: begin
        if (recover || (check_tick && hyst != 2'h0 && rec)) begin
          next_state = bpc_pkg::BPC_CLEAR;
        end
      end
      default: next_state = bpc_pkg::BPC_CLEAR;
    endcase
    if (!enable) begin
      next_state = bpc_pkg::BPC_CLEAR;
      next_cnt   = 8'h00;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= bpc_pkg::BPC_CLEAR;
      cnt   <= 8'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign fault = (state == bpc_pkg::BPC_TRIPPED);

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  sequence s_recover;
    fault && enable && check_tick && hyst != 2'h0 && rec;
  endsequence
  sequence s_hold;
    fault && enable && hyst == 2'h0 && !recover ##1 enable;
  endsequence

  AST_DISABLED: assert property (!enable |=> !fault)
    else $error("disabled protection raised its flag");
  AST_TRIP_CAUSE: assert property ($rose(fault) |-> $past(check_tick && cond))
    else $error("fault rose without a CHECK hit");
  AST_STREAK: assert property (!fault && check_tick && !cond |=> cnt == 8'h00)
    else $error("delay count kept after a miss");
  AST_ONE_HIT: assert property (enable && delay == 8'h01 && !fault && check_tick && cond |=> fault)
    else $error("one-interval delay did not trip");
  AST_RECOVER: assert property (s_recover |=> !fault)
    else $error("fault not cleared past hysteresis");
  AST_NO_AUTO: assert property (s_hold |-> fault)
    else $error("fault cleared with recovery disabled");
endmodule
`default_nettype wire

/* design/bpc_top.sv */
// Battery protection configuration registers and fault evaluation.
// Assumes measurement, tick and external fault inputs come from logic
// on the same clock, and a single-cycle register port master.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Enable mask A: one bit per protection
// - Enable mask B temperature bits, reset zero
// - Disabled protection never sets its flag
// - FET action comes from action masks
// - Discharge mask bits turn discharge FET off
// - Both mask diagnostics turn both FETs off
// - Open-wire enable bit, register reset 0x10
// - Enabled open-wire pulses cell current sources
// - Rate code selects activation frequency
// - Fastest rate at 250 ms stretches CHECK
// - Undervoltage threshold signed millivolts, default 2500
// - Undervoltage delay in CHECK intervals
// - Undervoltage clears at threshold plus hysteresis
// - Undervoltage hysteresis codes: none,50,100,200
// - Overvoltage threshold signed millivolts, default 4200
// - Overvoltage delay in CHECK intervals
// - Overvoltage clears at threshold minus hysteresis
// - Overvoltage hysteresis codes: none,50,100,200
module bpc_top (
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic [4:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  input  wire logic              check_tick,
  input  wire logic              sub_tick,
  input  wire logic              check_time_250ms,
  input  wire logic signed [15:0] max_cell_mv,
  input  wire logic signed [15:0] min_cell_mv,
  input  wire logic [5:0]        ext_fault_a,
  input  wire logic [7:0]        ext_fault_b,
  input  wire logic              diag_vref,
  input  wire logic              diag_vss,
  output logic                   discharge_fet_off,
  output logic                   charge_fet_off,
  output logic                   open_wire_source_on,
  output logic                   check_stretch,
  output logic                   irq
);

  ////////////////////////////////////////////////////////////////
  // Configuration state
  logic [7:0]  en_a;
  logic [7:0]  en_b;
  logic [7:0]  dsg_mask;
  logic [7:0]  both_mask;
  logic [7:0]  ow_cfg;
  logic [15:0] uv_thr;
  logic [7:0]  uv_dly;
  logic [1:0]  uv_hys;
  logic [15:0] ov_thr;
  logic [7:0]  ov_dly;
  logic [1:0]  ov_hys;
  logic [7:0]  next_en_a;
  logic [7:0]  next_en_b;
  logic [7:0]  next_dsg_mask;
  logic [7:0]  next_both_mask;
  logic [7:0]  next_ow_cfg;
  logic [15:0] next_uv_thr;
  logic [7:0]  next_uv_dly;
  logic [1:0]  next_uv_hys;
  logic [15:0] next_ov_thr;
  logic [7:0]  next_ov_dly;
  logic [1:0]  next_ov_hys;
  logic [1:0]  recover;
  logic [1:0]  next_recover;

  // Status, event and output state
  logic [7:0]  stat_a;
  logic [7:0]  stat_b;
  logic [7:0]  next_stat_a;
  logic [7:0]  next_stat_b;
  logic [3:0]  evt;
  logic [3:0]  evt_en;
  logic [3:0]  next_evt;
  logic [3:0]  next_evt_en;
  logic [3:0]  evt_clr;
  logic [3:0]  evt_new;
  logic        ov_prev;
  logic        uv_prev;
  logic        next_dsg_off;
  logic        next_chg_off;
  logic        next_stretch;
  logic        next_irq;
  logic [15:0] next_rdata;

  // Evaluator results
  logic        ov_fault;
  logic        uv_fault;
  logic        ow_pulse;

  ////////////////////////////////////////////////////////////////
  // Register writes; reserved bits are held at their fixed values
  always_comb begin
    next_en_a      = en_a;
    next_en_b      = en_b;
    next_dsg_mask  = dsg_mask;
    next_both_mask = both_mask;
    next_ow_cfg    = ow_cfg;
    next_uv_thr    = uv_thr;
    next_uv_dly    = uv_dly;
    next_uv_hys    = uv_hys;
    next_ov_thr    = ov_thr;
    next_ov_dly    = ov_dly;
    next_ov_hys    = ov_hys;
    next_evt_en    = evt_en;
    if (reg_wr) begin
      case (reg_addr)
        bpc_pkg::BPC_OFF_EN_A: begin
          next_en_a = reg_wdata[7:0];
        end
        bpc_pkg::BPC_OFF_EN_B: begin
          next_en_b = reg_wdata[7:0] & bpc_pkg::BPC_EN_B_WMASK;
        end
        bpc_pkg::BPC_OFF_DSG: begin
          next_dsg_mask = reg_wdata[7:0];
        end
        bpc_pkg::BPC_OFF_BOTH: begin
          next_both_mask = reg_wdata[7:0] & bpc_pkg::BPC_BOTH_WMASK;
        end
        bpc_pkg::BPC_OFF_OW: begin
          next_ow_cfg = (reg_wdata[7:0] & bpc_pkg::BPC_OW_WMASK)
                        | bpc_pkg::BPC_OW_ONES;
        end
        bpc_pkg::BPC_OFF_UV_THR: begin
          next_uv_thr = reg_wdata;
        end
        bpc_pkg::BPC_OFF_UV_DLY: begin
          next_uv_dly = reg_wdata[7:0];
        end
        bpc_pkg::BPC_OFF_UV_HYS: begin
          next_uv_hys = reg_wdata[1:0];
        end
        bpc_pkg::BPC_OFF_OV_THR: begin
          next_ov_thr = reg_wdata;
        end
        bpc_pkg::BPC_OFF_OV_DLY: begin
          next_ov_dly = reg_wdata[7:0];
        end
        bpc_pkg::BPC_OFF_OV_HYS: begin
          next_ov_hys = reg_wdata[1:0];
        end
        bpc_pkg::BPC_OFF_EVT_EN: begin
          next_evt_en = reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Manual recovery is a one-cycle pulse; with code 0 the only way out besides disabling the protection
  always_comb begin
    next_recover = 2'h0;
    evt_clr      = 4'h0;
    if (reg_wr && reg_addr == bpc_pkg::BPC_OFF_RECOVER) begin
      next_recover = reg_wdata[1:0];
    end
    if (reg_wr && reg_addr == bpc_pkg::BPC_OFF_EVT_CLR) begin
      evt_clr = reg_wdata[3:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      en_a      <= bpc_pkg::BPC_RST_EN_A;
      en_b      <= bpc_pkg::BPC_RST_EN_B;
      dsg_mask  <= bpc_pkg::BPC_RST_DSG;
      both_mask <= bpc_pkg::BPC_RST_BOTH;
      ow_cfg    <= bpc_pkg::BPC_RST_OW;
      uv_thr    <= bpc_pkg::BPC_RST_UV_THR;
      uv_dly    <= bpc_pkg::BPC_RST_DLY;
      uv_hys    <= bpc_pkg::BPC_RST_HYS;
      ov_thr    <= bpc_pkg::BPC_RST_OV_THR;
      ov_dly    <= bpc_pkg::BPC_RST_DLY;
      ov_hys    <= bpc_pkg::BPC_RST_HYS;
      evt_en    <= 4'h0;
      recover   <= 2'h0;
    end else begin
      en_a      <= next_en_a;
      en_b      <= next_en_b;
      dsg_mask  <= next_dsg_mask;
      both_mask <= next_both_mask;
      ow_cfg    <= next_ow_cfg;
      uv_thr    <= next_uv_thr;
      uv_dly    <= next_uv_dly;
      uv_hys    <= next_uv_hys;
      ov_thr    <= next_ov_thr;
      ov_dly    <= next_ov_dly;
      ov_hys    <= next_ov_hys;
      evt_en    <= next_evt_en;
      recover   <= next_recover;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Cell voltage evaluators
  bpc_volt_eval #(
    .OVER (1'b1)
  ) u_ov (
    .clock      (clock),
    .resetn     (resetn),
    .check_tick (check_tick),
    .enable     (en_a[bpc_pkg::BPC_A_OV]),
    .cell_mv    (max_cell_mv),
    .threshold  (ov_thr),
    .delay      (ov_dly),
    .hyst       (ov_hys),
    .recover    (recover[0]),
    .fault      (ov_fault)
  );

  bpc_volt_eval #(
    .OVER (1'b0)
  ) u_uv (
    .clock      (clock),
    .resetn     (resetn),
    .check_tick (check_tick),
    .enable     (en_a[bpc_pkg::BPC_A_UV]),
    .cell_mv    (min_cell_mv),
    .threshold  (uv_thr),
    .delay      (uv_dly),
    .hyst       (uv_hys),
    .recover    (recover[1]),
    .fault      (uv_fault)
  );

  // Open-wire source timing
  bpc_ow_sched u_ow (
    .clock      (clock),
    .resetn     (resetn),
    .check_tick (check_tick),
    .sub_tick   (sub_tick),
    .enable     (ow_cfg[bpc_pkg::BPC_OW_EN]),
    .rate       (ow_cfg[2:0]),
    .pulse      (ow_pulse)
  );

  ////////////////////////////////////////////////////////////////
  // Flags only pass where enabled; FET action uses masks alone
  always_comb begin
    next_stat_a = {ov_fault, uv_fault, ext_fault_a & en_a[5:0]};
    next_stat_b = ext_fault_b & en_b;
    next_dsg_off = |(dsg_mask & {next_stat_a[bpc_pkg::BPC_A_UV],
                                 next_stat_a[bpc_pkg::BPC_A_SC],
                                 next_stat_a[bpc_pkg::BPC_A_OC1],
                                 next_stat_a[bpc_pkg::BPC_A_OC2],
                                 1'b0,
                                 next_stat_b[bpc_pkg::BPC_B_OTD],
                                 next_stat_b[bpc_pkg::BPC_B_UTD],
                                 next_stat_b[bpc_pkg::BPC_B_OTI]});
    next_chg_off = |(both_mask[2:0] & {diag_vref, diag_vss,
                                       next_stat_a[bpc_pkg::BPC_A_REG]});
    next_dsg_off = next_dsg_off | next_chg_off;
    next_stretch = ow_cfg[bpc_pkg::BPC_OW_EN] && check_time_250ms
                   && ow_cfg[2:0] == bpc_pkg::BPC_OW_RATE_MAX;
  end

  ////////////////////////////////////////////////////////////////
  // Sticky events: a new event in a clear cycle survives the clear
  always_comb begin
    evt_new  = {~uv_fault & uv_prev, ~ov_fault & ov_prev,
                uv_fault & ~uv_prev, ov_fault & ~ov_prev};
    next_evt = (evt & ~evt_clr) | evt_new;
    next_irq = |(evt & evt_en);
  end

  ////////////////////////////////////////////////////////////////
  // Read data stands one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        bpc_pkg::BPC_OFF_EN_A:   next_rdata = {8'h00, en_a};
        bpc_pkg::BPC_OFF_EN_B:   next_rdata = {8'h00, en_b};
        bpc_pkg::BPC_OFF_DSG:    next_rdata = {8'h00, dsg_mask};
        bpc_pkg::BPC_OFF_BOTH:   next_rdata = {8'h00, both_mask};
        bpc_pkg::BPC_OFF_OW:     next_rdata = {8'h00, ow_cfg};
        bpc_pkg::BPC_OFF_UV_THR: next_rdata = uv_thr;
        bpc_pkg::BPC_OFF_UV_DLY: next_rdata = {8'h00, uv_dly};
        bpc_pkg::BPC_OFF_UV_HYS: next_rdata = {14'h0000, uv_hys};
        bpc_pkg::BPC_OFF_OV_THR: next_rdata = ov_thr;
        bpc_pkg::BPC_OFF_OV_DLY: next_rdata = {8'h00, ov_dly};
        bpc_pkg::BPC_OFF_OV_HYS: next_rdata = {14'h0000, ov_hys};
        bpc_pkg::BPC_OFF_STAT_A: next_rdata = {8'h00, stat_a};
        bpc_pkg::BPC_OFF_STAT_B: next_rdata = {8'h00, stat_b};
        bpc_pkg::BPC_OFF_EVT:    next_rdata = {12'h000, evt};
        bpc_pkg::BPC_OFF_EVT_EN: next_rdata = {12'h000, evt_en};
        default:                 next_rdata = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output and status registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stat_a              <= 8'h00;
      stat_b              <= 8'h00;
      evt                 <= 4'h0;
      ov_prev             <= 1'b0;
      uv_prev             <= 1'b0;
      discharge_fet_off   <= 1'b0;
      charge_fet_off      <= 1'b0;
      open_wire_source_on <= 1'b0;
      check_stretch       <= 1'b0;
      irq                 <= 1'b0;
      reg_rdata           <= 16'h0000;
    end else begin
      stat_a              <= next_stat_a;
      stat_b              <= next_stat_b;
      evt                 <= next_evt;
      ov_prev             <= ov_fault;
      uv_prev             <= uv_fault;
      discharge_fet_off   <= next_dsg_off;
      charge_fet_off      <= next_chg_off;
      open_wire_source_on <= ow_pulse;
      check_stretch       <= next_stretch;
      irq                 <= next_irq;
      reg_rdata           <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  AST_DSG_ACTION: assert property (uv_fault && dsg_mask[7] |=> discharge_fet_off)
    else $error("undervoltage did not turn discharge FET off");
  AST_BOTH_ACTION: assert property (diag_vref && both_mask[2] |=> charge_fet_off && discharge_fet_off)
    else $error("reference diagnostic did not turn both FETs off");
  AST_MASK_ONLY: assert property (both_mask[2:0] == 3'h0 |=> !charge_fet_off)
    else $error("charge FET turned off with empty action mask");
  AST_GATE_B: assert property (!en_b[bpc_pkg::BPC_B_OTD] |=> !stat_b[bpc_pkg::BPC_B_OTD])
    else $error("disabled protection set its status flag");
  AST_STRETCH: assert property (ow_cfg[3] && ow_cfg[2:0] == 3'h7 && check_time_250ms |=> check_stretch)
    else $error("CHECK interval not stretched");
  AST_OW_RESERVED: assert property (ow_cfg[4] && en_b[0] == 1'b0)
    else $error("reserved configuration bit altered");
  AST_IRQ: assert property (evt_new[0] && evt_en[0] |-> ##2 irq)
    else $error("enabled event did not raise interrupt");
endmodule
`default_nettype wire

/* tb/bpc_cell_model.sv */
// Model of the measurement timing that the cell stack side supplies.
// Assumes one clock; the bench drives the cell voltages itself.
`timescale 1ns/10ps
`default_nettype none
module bpc_cell_model (
  input  wire logic clock,
  input  wire logic resetn,
  output logic      check_tick,
  output logic      sub_tick
);
  logic [5:0] phase;
  // Free running phase; a 64-cycle interval keeps the run short
  always_ff @(posedge clock) begin
    if (!resetn) phase <= 6'h00;
    else phase <= phase + 6'h01;
  end
  // Sixteen sub ticks per interval, the last one lands with the check
  assign sub_tick   = resetn && (phase[1:0] == 2'h3);
  assign check_tick = resetn && (phase == 6'h3F);
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the protection configuration block.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, ct, st, cts = 0, vref = 0, vss = 0;
  logic [5:0] exa = 6'h00;
  logic [7:0] exb = 8'hFF;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, v;
  logic signed [15:0] max_mv = 16'sd3700, min_mv = 16'sd3600;
  logic dsg_off, both_off, ow_on, stretch, irq;
  int errors = 0, tests_run = 0, cycles = 0, n;
  logic [15:0] dflt [11] = '{16'h00A1, 16'h0000, 16'h00FF, 16'h0006, 16'h0010, 16'h09C4,
                             16'h000A, 16'h0002, 16'h1068, 16'h000A, 16'h0002};
  bpc_cell_model cells (.clock(clock), .resetn(resetn), .check_tick(ct), .sub_tick(st));
  bpc_top dut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .check_tick(ct), .sub_tick(st),
    .check_time_250ms(cts), .max_cell_mv(max_mv), .min_cell_mv(min_mv), .ext_fault_a(exa),
    .ext_fault_b(exb), .diag_vref(vref), .diag_vss(vss), .discharge_fet_off(dsg_off),
    .charge_fet_off(both_off), .open_wire_source_on(ow_on), .check_stretch(stretch), .irq(irq));
  initial begin
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe; the edge closing it still sees them
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
  // FET outputs follow the tripping tick by two cycles, the interrupt by three
  task automatic ticks(input int k);
    repeat (k) @(posedge clock iff ct);
    repeat (3) @(posedge clock);
  endtask
  task automatic owc(output int c);
    c = 0;
    @(posedge clock iff ct);
    repeat (256) begin
      @(posedge clock);
      c += ow_on;
    end
  endtask
  task automatic summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(5'(i), v); chk(v, dflt[i]);
    end
    rd(5'h0D, v); chk(v, 16'h0000);
    wr(5'h01, 16'hFFFF); rd(5'h01, v); chk(v, 16'h003E);
    rd(5'h0D, v); chk(v, 16'h003E); chk(16'(dsg_off), 16'h0001);
    exb <= 8'h00;
    wr(5'h04, 16'h00E0); rd(5'h04, v); chk(v, 16'h0010);
    rd(5'h1F, v); chk(v, 16'h0000);
    // Undervoltage is off by default, a low cell must not trip it
    min_mv <= 16'sd2499; ticks(2); rd(5'h0C, v); chk(v, 16'h0000);
    chk(16'(dsg_off), 16'h0000);
    wr(5'h06, 16'h0001); wr(5'h00, 16'h00E1); ticks(1); chk(16'(dsg_off), 16'h0001);
    rd(5'h0C, v); chk(v, 16'h0040);
    min_mv <= 16'sd2599; ticks(1); chk(16'(dsg_off), 16'h0001);
    min_mv <= 16'sd2600; ticks(1); chk(16'(dsg_off), 16'h0000);
    // Overvoltage with a two-interval delay; a gap restarts the count
    wr(5'h10, 16'h0001); wr(5'h09, 16'h0002);
    max_mv <= 16'sd4201; ticks(1); max_mv <= 16'sd4200; ticks(1);
    max_mv <= 16'sd4201; ticks(1); chk(16'(irq), 16'h0000);
    ticks(1); chk(16'(irq), 16'h0001); rd(5'h0C, v); chk(v, 16'h0080);
    wr(5'h0A, 16'h0003); max_mv <= 16'sd4001; ticks(1); rd(5'h0C, v); chk(v, 16'h0080);
    max_mv <= 16'sd4000; ticks(1); rd(5'h0C, v); chk(v, 16'h0000);
    // Code 0 holds the fault until software asks for recovery
    wr(5'h0A, 16'h0000); max_mv <= 16'sd4300; ticks(2); rd(5'h0C, v); chk(v, 16'h0080);
    max_mv <= 16'sd3000; ticks(1); rd(5'h0C, v); chk(v, 16'h0080);
    wr(5'h0B, 16'h0001); ticks(1); rd(5'h0C, v); chk(v, 16'h0000);
    wr(5'h0F, 16'h000F); repeat (2) @(posedge clock); chk(16'(irq), 16'h0000);
    vref <= 1'b1; repeat (3) @(posedge clock); chk(16'(both_off), 16'h0001);
    chk(16'(dsg_off), 16'h0001);
    vref <= 1'b0;
    vss <= 1'b1; repeat (3) @(posedge clock); chk(16'(both_off), 16'h0001);
    // Regulator flag is enabled but its both-FET bit is clear by default
    vss <= 1'b0; exa <= 6'h3F; repeat (3) @(posedge clock); chk(16'(both_off), 16'h0000);
    chk(16'(dsg_off), 16'h0001); rd(5'h0C, v); chk(v, 16'h0021);
    wr(5'h03, 16'h0007); repeat (2) @(posedge clock); chk(16'(both_off), 16'h0001);
    exa <= 6'h00;
    // Rates 3 to 7 double the activations each step over four intervals
    cts <= 1'b1;
    for (int c = 3; c < 8; c++) begin
      wr(5'h04, 16'(8 + c)); owc(n); chk(16'(n), 16'(4 << (c - 3)));
      chk(16'(stretch), 16'(c == 7));
    end
    summarize();
  end
endmodule
`default_nettype wire
